// ### core/dpb_pkg.sv
// dpb_pkg: constants shared by both ends and the bench
// assumes: every use is written dpb_pkg::name
package dpb_pkg;

	////////////////////////////////////////////////////////////////////////////
	// parameter block layout
	localparam int         BLK_LEN   = 7; // bytes in one parameter block
	localparam logic [2:0] IDX_CHAN  = 3'h0; // channel control word
	localparam logic [2:0] IDX_INSTR = 3'h1; // instruction byte
	localparam logic [2:0] IDX_COUNT = 3'h2; // record count
	localparam logic [2:0] IDX_TRACK = 3'h3; // track
	localparam logic [2:0] IDX_SECT  = 3'h4; // starting sector
	localparam logic [2:0] IDX_BUFL  = 3'h5; // buffer pointer, low byte
	localparam logic [2:0] IDX_BUFH  = 3'h6; // buffer pointer, high byte
	localparam logic [2:0] IDX_LAST  = 3'h6; // last byte fetched

	// channel word and instruction fields
	localparam int CW_RANDOM_BIT = 6; // 1: sector pattern from buffer
	localparam int CW_IRQ_LO     = 4; // interrupt control, bits 5:4
	localparam int WLEN_BIT      = 3; // word length, both bytes
	localparam int IN_UNIT_LO    = 4; // unit select, bits 5:4
	localparam int IN_OP_LO      = 0; // op code, bits 2:0

	localparam logic [1:0] IRQ_MODE_ALL = 2'h0;  // completion and error interrupts
	localparam logic [1:0] IRQ_MODE_OFF = 2'h1;  // completion interrupts off

	// op codes
	localparam logic [2:0] OP_NOP   = 3'h0;
	localparam logic [2:0] OP_SEEK  = 3'h1;
	localparam logic [2:0] OP_FMT   = 3'h2;
	localparam logic [2:0] OP_RECAL = 3'h3;
	localparam logic [2:0] OP_READ  = 3'h4;
	localparam logic [2:0] OP_VRFY  = 3'h5;
	localparam logic [2:0] OP_WRITE = 3'h6;
	localparam logic [2:0] OP_WDEL  = 3'h7;

	// address limits
	localparam logic [7:0] TRACK_MAX  = 8'h4C;   // last legal track
	localparam logic [8:0] SECTOR_MAX = 9'h034;  // last sector of a track

	////////////////////////////////////////////////////////////////////////////
	// result byte
	localparam int         RB_NOT_READY = 7;
	localparam int         RB_WFAULT    = 6;
	localparam int         RB_WPROT     = 5;
	localparam int         RB_OVERRUN   = 4;
	localparam int         RB_ADDR      = 3;
	localparam int         RB_SEEK      = 2;
	localparam int         RB_CRC       = 1;
	localparam int         RB_DELETED   = 0;
	localparam logic [7:0] RESULT_RST   = 8'h00;
	localparam logic [7:0] RES_TYPE_ERR = 8'h00; // result type: error byte follows

	// result read selector on the link
	localparam logic RD_SEL_TYPE = 1'b0;
	localparam logic RD_SEL_BYTE = 1'b1;

	////////////////////////////////////////////////////////////////////////////
	// host end register map (byte addresses)
	localparam logic [9:0] REG_POINTER = 10'h000;
	localparam logic [9:0] REG_STATUS  = 10'h004;
	localparam logic [9:0] REG_RESULT  = 10'h008;
	localparam logic [9:0] REG_COMMAND = 10'h00C;
	localparam logic [9:0] MEM_BASE    = 10'h100;
	localparam int         ST_BUSY     = 0;
	localparam int         ST_RES_OK   = 1;
	localparam int         ST_IRQ_SEEN = 2;
	localparam int         CMD_FETCH   = 0;

endpackage

// ### core/dpb_link_if.sv
// dpb_link_if: link joining the two ends
// assumes: one clock shared by both ends, every signal driven from a flop except busy, decoded from the device state
`timescale 1ns/1ps
`default_nettype none
interface dpb_link_if (
	input wire logic core_clk
);
	logic        ptr_load;   // pointer load pulse, host to device
	logic [15:0] ptr;        // block pointer, valid with ptr_load
	logic        mem_req;    // memory byte request, held until mem_ack
	logic [15:0] mem_addr;   // byte address of the request
	logic        mem_ack;    // one-cycle answer with mem_rdata
	logic [7:0]  mem_rdata;  // byte read from shared memory
	logic        rd_req;     // result read request, held until rd_ack
	logic        rd_sel;     // type or result byte
	logic        rd_ack;     // one-cycle answer with rd_data
	logic [7:0]  rd_data;    // result type or result byte
	logic        busy;       // operation in progress
	logic        irq;        // one-cycle interrupt request

	modport dev (input ptr_load, ptr, mem_ack, mem_rdata, rd_req, rd_sel,
		output mem_req, mem_addr, rd_ack, rd_data, busy, irq);
	modport host (output ptr_load, ptr, mem_ack, mem_rdata, rd_req, rd_sel,
		input mem_req, mem_addr, rd_ack, rd_data, busy, irq);
endinterface
`default_nettype wire

// ### core/dpb_host_end.sv
// dpb_host_end: avalon slave, pointer loads, shared memory, result reads
// assumes: software writes the block into the memory window before the pointer
`timescale 1ns/1ps
`default_nettype none
module dpb_host_end #(
	parameter int MEM_AW = 6                   // shared memory address bits
) (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// avalon-mm slave
	input  wire logic [9:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// link
	dpb_link_if.host         lnk
);
	typedef enum {HS_IDLE, HS_TYPE, HS_BYTE} dpb_hstate_t;

	logic [7:0]  mem [0:(1<<MEM_AW)-1]; // shared memory bytes
	logic [15:0] ptr_r, ptr_nxt; // last pointer written
	logic        pl_r, pl_nxt; // pointer load pulse
	logic        wait_r, wait_nxt; // waitrequest
	logic [31:0] rdat_r, rdat_nxt; // read data
	logic        mack_r, mack_nxt; // memory answer
	logic [7:0]  mdat_r, mdat_nxt;
	logic        rq_r, rq_nxt; // result read request
	logic        sel_r, sel_nxt;
	logic [7:0]  res_r, res_nxt; // result byte copy
	logic        rok_r, rok_nxt; // result byte valid
	logic        irqs_r, irqs_nxt; // interrupt seen
	dpb_hstate_t hs_r, hs_nxt;
	logic        acc; // access completes this cycle
	logic        in_mem;

	////////////////////////////////////////////////////////////////////////////
	// next values
	always_comb begin
		acc      = (avs_read | avs_write) & ~wait_r;
		in_mem   = avs_address >= dpb_pkg::MEM_BASE;
		ptr_nxt  = ptr_r;
		pl_nxt   = 1'b0;
		rdat_nxt = rdat_r;
		res_nxt  = res_r;
		rok_nxt  = rok_r;
		rq_nxt   = rq_r;
		sel_nxt  = sel_r;
		hs_nxt   = hs_r;
		// one wait cycle per access; the edge with waitrequest low completes it
		wait_nxt = ~((avs_read | avs_write) & wait_r);
		// memory answers next cycle, then drops one
		mack_nxt = lnk.mem_req & ~mack_r;
		mdat_nxt = mem[lnk.mem_addr[MEM_AW-1:0]];
		// set wins over software clear
		irqs_nxt = irqs_r;
		if (acc && avs_write && avs_address == dpb_pkg::REG_STATUS && avs_writedata[dpb_pkg::ST_IRQ_SEEN])
			irqs_nxt = 1'b0;
		if (lnk.irq)
			irqs_nxt = 1'b1;
		// read data loads as waitrequest falls
		if (avs_read && wait_r) begin
			case (avs_address)
				dpb_pkg::REG_POINTER: rdat_nxt = {16'h0, ptr_r};
				dpb_pkg::REG_STATUS:  rdat_nxt = {29'h0, irqs_r, rok_r, lnk.busy};
				dpb_pkg::REG_RESULT:  rdat_nxt = {24'h0, res_r};
				default:              rdat_nxt = in_mem ? {24'h0, mem[avs_address[MEM_AW+1:2]]} : 32'h0;
			endcase
		end
		// pointer write starts an operation
		if (acc && avs_write && avs_address == dpb_pkg::REG_POINTER) begin
			ptr_nxt = avs_writedata[15:0];
			pl_nxt  = 1'b1;
			rok_nxt = 1'b0;
		end
		// result fetch: type query, then the byte only after type 00
		case (hs_r)
			HS_IDLE: begin
				if (acc && avs_write && avs_address == dpb_pkg::REG_COMMAND && avs_writedata[dpb_pkg::CMD_FETCH]) begin
					rq_nxt  = 1'b1;
					sel_nxt = dpb_pkg::RD_SEL_TYPE;
					rok_nxt = 1'b0;
					hs_nxt  = HS_TYPE;
				end
			end
			HS_TYPE: begin
				if (lnk.rd_ack) begin
					rq_nxt  = lnk.rd_data == dpb_pkg::RES_TYPE_ERR;
					sel_nxt = dpb_pkg::RD_SEL_BYTE;
					hs_nxt  = rq_nxt ? HS_BYTE : HS_IDLE;
				end
			end
			HS_BYTE: begin
				if (lnk.rd_ack) begin
					rq_nxt  = 1'b0;
					res_nxt = lnk.rd_data;
					rok_nxt = 1'b1;
					hs_nxt  = HS_IDLE;
				end
			end
			default: hs_nxt = HS_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ptr_r  <= 16'h0000;
			pl_r   <= 1'b0;
			wait_r <= 1'b1;
			rdat_r <= 32'h0000_0000;
			mack_r <= 1'b0;
			mdat_r <= 8'h00;
			rq_r   <= 1'b0;
			sel_r  <= dpb_pkg::RD_SEL_TYPE;
			res_r  <= dpb_pkg::RESULT_RST;
			rok_r  <= 1'b0;
			irqs_r <= 1'b0;
			hs_r   <= HS_IDLE;
		end else begin
			ptr_r  <= ptr_nxt;
			pl_r   <= pl_nxt;
			wait_r <= wait_nxt;
			rdat_r <= rdat_nxt;
			mack_r <= mack_nxt;
			mdat_r <= mdat_nxt;
			rq_r   <= rq_nxt;
			sel_r  <= sel_nxt;
			res_r  <= res_nxt;
			rok_r  <= rok_nxt;
			irqs_r <= irqs_nxt;
			hs_r   <= hs_nxt;
		end
	end

	// memory window, byte per word; contents have no reset
	always_ff @(posedge core_clk) begin
		if (acc && avs_write && in_mem)
			mem[avs_address[MEM_AW+1:2]] <= avs_writedata[7:0];
	end

	assign avs_readdata    = rdat_r;
	assign avs_waitrequest = wait_r;
	assign lnk.ptr_load    = pl_r;
	assign lnk.ptr         = ptr_r;
	assign lnk.mem_ack     = mack_r;
	assign lnk.mem_rdata   = mdat_r;
	assign lnk.rd_req      = rq_r;
	assign lnk.rd_sel      = sel_r;
endmodule
`default_nettype wire

// ### core/dpb_dev_end.sv
// dpb_dev_end: fetches and checks the parameter block, starts the drive, builds the result
// assumes: drive pins asynchronous; datapath strobes on core_clk
//
// Behaviour
// - pointer load starts a parameter block fetch
// - seven bytes fetched in fixed order
// - channel bit 6 picks random format sequence
// - host keeps word-length bits equal, 0/1
// - bits 5:4 gate completion and error interrupts
// - ready changes always interrupt
// - unit bits 5:4 select drive 0-3
// - three-bit op code decoded to operation
// - record count bounded by last sector
// - track 0 to 76 accepted
// - sector from bits 5:0, 1 to 52
// - buffer bytes joined into 16-bit address
// - result byte read after type 00
// - bit 7: drive not ready
// - bit 6: write fault during write
// - bit 5: write protect on writing ops
// - bit 4: overrun or underrun
// - bit 3: address error
// - bit 2: seek error
// - bit 1: data CRC on read/verify
// - bit 0: deleted mark on read/verify
// - combined codes set several bits
// - random format buffer holds sector, fill pairs
`timescale 1ns/1ps
`default_nettype none
module dpb_dev_end (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// link to host
	dpb_link_if.dev          lnk,
	// drive status pins, asynchronous
	input  wire logic        drv_ready,
	input  wire logic        drv_wprot,
	input  wire logic        drv_wfault,
	// datapath strobes, same clock
	input  wire logic        dp_done,
	input  wire logic        dp_overrun,
	input  wire logic        dp_seek_err,
	input  wire logic        dp_crc_err,
	input  wire logic        dp_deleted,
	input  wire logic        dp_id_crc_err,
	input  wire logic        dp_no_addr_mark,
	input  wire logic        dp_no_data_mark,
	// decoded operation to datapath
	output logic             op_start,
	output logic      [2:0]  op_code,
	output logic      [1:0]  drive_sel,
	output logic      [7:0]  track,
	output logic      [5:0]  sector,
	output logic      [7:0]  rec_count,
	output logic      [15:0] buf_addr,
	output logic             fmt_random
);
	typedef enum {DS_IDLE, DS_REQ, DS_GAP, DS_CHECK, DS_RUN, DS_FINISH} dpb_dstate_t;

	// writing ops check protect and fault
	function automatic logic is_write(input logic [2:0] op);
		is_write = (op == dpb_pkg::OP_FMT) || (op == dpb_pkg::OP_WRITE) || (op == dpb_pkg::OP_WDEL);
	endfunction

	// reading ops report CRC and deleted marks
	function automatic logic is_read(input logic [2:0] op);
		is_read = (op == dpb_pkg::OP_READ) || (op == dpb_pkg::OP_VRFY);
	endfunction

	dpb_dstate_t st_r, st_nxt; // sequencer
	logic [7:0]  blk_r [0:dpb_pkg::BLK_LEN-1]; // fetched block
	logic [7:0]  blk_nxt [0:dpb_pkg::BLK_LEN-1];
	logic [2:0]  idx_r, idx_nxt; // byte being fetched
	logic [15:0] base_r, base_nxt; // block pointer
	logic [15:0] addr_r, addr_nxt; // memory request address
	logic        req_r, req_nxt;
	logic [7:0]  res_r, res_nxt; // result byte
	logic        ack_r, ack_nxt;
	logic [7:0]  rdat_r, rdat_nxt;
	logic        irq_r, irq_nxt;
	logic        go_r, go_nxt; // op_start pulse
	logic [2:0]  s1_r, s2_r, s3_r; // pin synchroniser stages
	logic [2:0]  stb_r, stb_nxt; // filtered pins: ready, wprot, wfault
	logic [2:0]  op;
	logic [8:0]  sec_end;
	logic        addr_bad;
	logic [7:0]  err;

	////////////////////////////////////////////////////////////////////////////
	// pin filter: a change counts once stages two and three agree
	always_comb begin
		stb_nxt = (s2_r & ~(s2_r ^ s3_r)) | (stb_r & (s2_r ^ s3_r));
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			s1_r  <= 3'h0;
			s2_r  <= 3'h0;
			s3_r  <= 3'h0;
			stb_r <= 3'h0;
		end else begin
			s1_r  <= {drv_wfault, drv_wprot, drv_ready};
			s2_r  <= s1_r;
			s3_r  <= s2_r;
			stb_r <= stb_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// decode and limit checks on the held block
	always_comb begin
		op      = blk_r[dpb_pkg::IDX_INSTR][dpb_pkg::IN_OP_LO +: 3];
		// start plus count must stay within the track
		sec_end = {3'h0, blk_r[dpb_pkg::IDX_SECT][5:0]} + {1'b0, blk_r[dpb_pkg::IDX_COUNT]};
		addr_bad = 1'b0;
		if (op != dpb_pkg::OP_NOP && op != dpb_pkg::OP_RECAL)
			addr_bad = blk_r[dpb_pkg::IDX_TRACK] > dpb_pkg::TRACK_MAX;
		if (is_read(op) || op == dpb_pkg::OP_WRITE || op == dpb_pkg::OP_WDEL) begin
			// only the low six sector bits count
			if (blk_r[dpb_pkg::IDX_SECT][5:0] == 6'h00 ||
				{3'h0, blk_r[dpb_pkg::IDX_SECT][5:0]} > dpb_pkg::SECTOR_MAX ||
				sec_end > dpb_pkg::SECTOR_MAX)
				addr_bad = 1'b1;
		end
		// error strobes to result bits
		err = 8'h00;
		err[dpb_pkg::RB_NOT_READY] = ~stb_r[0]; // drops out while running
		err[dpb_pkg::RB_WFAULT]    = stb_r[2] & is_write(op);
		err[dpb_pkg::RB_OVERRUN]   = dp_overrun;
		err[dpb_pkg::RB_SEEK]      = dp_seek_err; // any op may move the head
		err[dpb_pkg::RB_CRC]       = dp_crc_err & is_read(op);
		err[dpb_pkg::RB_DELETED]   = dp_deleted & is_read(op);
		// combined codes
		if (dp_id_crc_err)
			err = err | 8'h0A;
		if (dp_no_addr_mark)
			err = err | 8'h0E;
		if (dp_no_data_mark)
			err = err | 8'h0F;
	end

	////////////////////////////////////////////////////////////////////////////
	// sequencer next values
	always_comb begin
		st_nxt   = st_r;
		blk_nxt  = blk_r;
		idx_nxt  = idx_r;
		base_nxt = base_r;
		addr_nxt = addr_r;
		req_nxt  = 1'b0;
		res_nxt  = res_r;
		go_nxt   = 1'b0;
		irq_nxt  = 1'b0;
		// result reads: answer next cycle, then drop one
		ack_nxt  = lnk.rd_req & ~ack_r;
		rdat_nxt = rdat_r;
		if (lnk.rd_req && !ack_r)
			rdat_nxt = (lnk.rd_sel == dpb_pkg::RD_SEL_BYTE) ? res_r : dpb_pkg::RES_TYPE_ERR;
		// drive ready changes interrupt in any mode
		if (stb_r[0] != stb_nxt[0])
			irq_nxt = 1'b1;
		case (st_r)
			DS_IDLE: begin
				// a pointer load while busy is ignored
				if (lnk.ptr_load) begin
					base_nxt = lnk.ptr;
					addr_nxt = lnk.ptr;
					idx_nxt  = dpb_pkg::IDX_CHAN;
					res_nxt  = dpb_pkg::RESULT_RST;
					req_nxt  = 1'b1;
					st_nxt   = DS_REQ;
				end
			end
			DS_REQ: begin
				req_nxt = ~lnk.mem_ack;
				if (lnk.mem_ack) begin
					// bytes land in block order
					blk_nxt[idx_r] = lnk.mem_rdata;
					st_nxt = (idx_r == dpb_pkg::IDX_LAST) ? DS_CHECK : DS_GAP;
				end
			end
			DS_GAP: begin
				// one idle cycle between bytes keeps the answer pairing simple
				idx_nxt  = idx_r + 3'h1;
				addr_nxt = base_r + {13'h0000, idx_nxt};
				req_nxt  = 1'b1;
				st_nxt   = DS_REQ;
			end
			DS_CHECK: begin
				if (op == dpb_pkg::OP_NOP) begin
					st_nxt = DS_FINISH;
				end else begin
					res_nxt[dpb_pkg::RB_NOT_READY] = ~stb_r[0];
					res_nxt[dpb_pkg::RB_WPROT]     = stb_r[1] & is_write(op);
					res_nxt[dpb_pkg::RB_ADDR]      = addr_bad;
					// a faulted operation never reaches the drive
					if (res_nxt != dpb_pkg::RESULT_RST) begin
						st_nxt = DS_FINISH;
					end else begin
						go_nxt = 1'b1;
						st_nxt = DS_RUN;
					end
				end
			end
			DS_RUN: begin
				res_nxt = res_r | err;
				if (dp_done)
					st_nxt = DS_FINISH;
			end
			DS_FINISH: begin
				// completion interrupt only in mode 00
				if (blk_r[dpb_pkg::IDX_CHAN][dpb_pkg::CW_IRQ_LO +: 2] == dpb_pkg::IRQ_MODE_ALL)
					irq_nxt = 1'b1;
				st_nxt = DS_IDLE;
			end
			default: st_nxt = DS_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// sequencer registers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_r   <= DS_IDLE;
			for (int i = 0; i < dpb_pkg::BLK_LEN; i++)
				blk_r[i] <= 8'h00;
			idx_r  <= dpb_pkg::IDX_CHAN;
			base_r <= 16'h0000;
			addr_r <= 16'h0000;
			req_r  <= 1'b0;
			res_r  <= dpb_pkg::RESULT_RST;
			ack_r  <= 1'b0;
			rdat_r <= 8'h00;
			irq_r  <= 1'b0;
			go_r   <= 1'b0;
		end else begin
			st_r   <= st_nxt;
			blk_r  <= blk_nxt;
			idx_r  <= idx_nxt;
			base_r <= base_nxt;
			addr_r <= addr_nxt;
			req_r  <= req_nxt;
			res_r  <= res_nxt;
			ack_r  <= ack_nxt;
			rdat_r <= rdat_nxt;
			irq_r  <= irq_nxt;
			go_r   <= go_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs from flops, except busy, decoded from the sequencer state
	assign lnk.mem_req   = req_r;
	assign lnk.mem_addr  = addr_r;
	assign lnk.rd_ack    = ack_r;
	assign lnk.rd_data   = rdat_r;
	assign lnk.busy      = st_r != DS_IDLE;
	assign lnk.irq       = irq_r;
	assign op_start      = go_r;
	assign op_code       = blk_r[dpb_pkg::IDX_INSTR][dpb_pkg::IN_OP_LO +: 3];
	assign drive_sel     = blk_r[dpb_pkg::IDX_INSTR][dpb_pkg::IN_UNIT_LO +: 2];
	assign track         = blk_r[dpb_pkg::IDX_TRACK];
	assign sector        = blk_r[dpb_pkg::IDX_SECT][5:0];
	assign rec_count     = blk_r[dpb_pkg::IDX_COUNT];
	assign buf_addr      = {blk_r[dpb_pkg::IDX_BUFH], blk_r[dpb_pkg::IDX_BUFL]};
	assign fmt_random    = blk_r[dpb_pkg::IDX_CHAN][dpb_pkg::CW_RANDOM_BIT];
endmodule
`default_nettype wire

// ### tb/dpb_monitor.sv
// dpb_monitor: timing checks on the link
// assumes: beside the link interface; one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
module dpb_monitor (
	// clock and reset
	input wire logic        core_clk,
	input wire logic        rst,
	// link signals
	input wire logic        ptr_load,
	input wire logic [15:0] ptr,
	input wire logic        mem_req,
	input wire logic [15:0] mem_addr,
	input wire logic        mem_ack,
	input wire logic        rd_req,
	input wire logic        rd_sel,
	input wire logic        rd_ack,
	input wire logic [7:0]  rd_data,
	input wire logic        busy,
	input wire logic        irq
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////////
	logic [2:0] got_r;    // block bytes answered so far
	logic [2:0] got_nxt;  // its next value
	// an accepted pointer restarts the count, each answer adds one
	always_comb begin
		got_nxt = got_r;
		if (ptr_load && !busy) begin
			got_nxt = 3'h0;
		end else if (mem_ack) begin
			got_nxt = got_r + 3'h1;
		end
	end
	// count register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			got_r <= 3'h0;
		end else begin
			got_r <= got_nxt;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// idle cycle, then next byte
	sequence s_next_byte;
		!mem_req ##1 (mem_req && mem_addr == $past(mem_addr, 2) + 16'h0001);
	endsequence
	// quiet after the last byte
	sequence s_quiet;
		!mem_req [*4];
	endsequence
	AST_FETCH_START: assert property (ptr_load && !busy |=> busy && mem_req && mem_addr == $past(ptr))
		else $error("fetch did not start at the pointer");
	AST_REQ_BUSY: assert property (mem_req |-> busy)
		else $error("memory request while idle");
	AST_MEM_HOLD: assert property (mem_req && !mem_ack |=> mem_ack && mem_req && $stable(mem_addr))
		else $error("memory request dropped or not answered");
	AST_NEXT_BYTE: assert property (mem_ack && got_r < dpb_pkg::IDX_LAST |=> s_next_byte)
		else $error("block byte skipped or out of order");
	AST_BLOCK_END: assert property (mem_ack && got_r == dpb_pkg::IDX_LAST |=> s_quiet)
		else $error("fetch went past seven bytes");
	AST_RD_ANSWER: assert property (rd_req && !rd_ack |=> rd_ack)
		else $error("result read not answered");
	AST_TYPE_CODE: assert property (rd_ack && !$past(rd_sel) |-> rd_data == dpb_pkg::RES_TYPE_ERR)
		else $error("result type is not the error type");
	AST_IDLE_READ: assert property (rd_req |-> !busy)
		else $error("result read during an operation");
	AST_IRQ_PULSE: assert property (irq |=> !irq)
		else $error("interrupt longer than one cycle");
endmodule
`default_nettype wire

// ### tb/testbench.sv
// testbench: host and decoder ends on one link; bench drives avalon, pins, datapath
// assumes: package, interface, both ends and the monitor compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        core_clk = 1'b0; // 40 MHz
	logic        rst = 1'b1; // synchronous reset
	logic [9:0]  avs_address = 10'h000; // avalon master
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        drv_ready = 1'b0; // drive pins
	logic        drv_wprot = 1'b0;
	logic        drv_wfault = 1'b0;
	logic [6:0]  dp_err = 7'h00; // overrun, seek, crc, deleted, id crc, no addr, no data
	logic [6:0]  inj = 7'h00; // errors for the next run
	logic [1:0]  dl = 2'h0; // datapath run length
	logic        dp_done;
	logic        op_start;
	logic        fmt_random;
	logic [2:0]  op_code;
	logic [1:0]  drive_sel;
	logic [7:0]  track;
	logic [7:0]  rec_count;
	logic [5:0]  sector;
	logic [15:0] buf_addr;
	logic [28:0] cap = 29'h0; // decoded fields seen at op_start
	logic [15:0] cap_buf = 16'h0000;
	int          bad_count = 0;
	int          comparisons = 0;
	always #12.5 core_clk = ~core_clk;
	////////////////////////////////////////////////////////////////////////////
	dpb_link_if lnk (.core_clk(core_clk));
	dpb_host_end u_dpb_host_end (.core_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .lnk);
	dpb_dev_end u_dpb_dev_end (.core_clk, .rst, .lnk, .drv_ready, .drv_wprot, .drv_wfault, .dp_done,
		.dp_overrun(dp_err[0]), .dp_seek_err(dp_err[1]), .dp_crc_err(dp_err[2]), .dp_deleted(dp_err[3]),
		.dp_id_crc_err(dp_err[4]), .dp_no_addr_mark(dp_err[5]), .dp_no_data_mark(dp_err[6]), .op_start,
		.op_code, .drive_sel, .track, .sector, .rec_count, .buf_addr, .fmt_random);
	dpb_monitor u_dpb_monitor (.core_clk, .rst, .ptr_load(lnk.ptr_load), .ptr(lnk.ptr),
		.mem_req(lnk.mem_req), .mem_addr(lnk.mem_addr), .mem_ack(lnk.mem_ack), .rd_req(lnk.rd_req),
		.rd_sel(lnk.rd_sel), .rd_ack(lnk.rd_ack), .rd_data(lnk.rd_data), .busy(lnk.busy), .irq(lnk.irq));
	////////////////////////////////////////////////////////////////////////////
	// datapath stand-in: records fields, holds errors, then done
	always @(posedge core_clk) begin
		if (op_start === 1'b1) begin
			cap <= {1'b1, op_code, drive_sel, fmt_random, track, sector, rec_count};
			cap_buf <= buf_addr;
			dp_err <= inj;
			dl <= 2'h3;
		end else if (dl != 2'h0) begin
			dl <= dl - 2'h1;
		end else begin
			dp_err <= 7'h00;
		end
	end
	assign dp_done = (dl == 2'h1);
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// one avalon access, held until waitrequest low; bounded
	task automatic av(input logic wr, input logic [9:0] a, input logic [31:0] d, output logic [31:0] q);
		int n = 0;
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 40);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			bad_count++;
			end_sim();
		end
	endtask
	// bounded poll of one status bit
	task automatic wait_st(input int b, input logic v);
		logic [31:0] q;
		int          n = 0;
		do begin
			av(1'b0, dpb_pkg::REG_STATUS, 32'h0, q);
			n++;
		end while (q[b] !== v && n < 80);
		chk({31'h0, q[b]}, {31'h0, v});
		if (q[b] !== v) begin
			end_sim();
		end
	endtask
	// random channel word, word-length bits equal
	function automatic logic [55:0] mk(input logic [2:0] op, input logic [7:0] trk, input logic [7:0] sec,
		input logic [7:0] cnt);
		logic [7:0] ch;
		logic [7:0] ins;
		ch = 8'($urandom) & 8'h78;
		ins = {2'b00, 2'($urandom), ch[3], op};
		return {16'($urandom), sec, trk, cnt, ins, ch};
	endfunction
	// expected result; bit 8: op reaches datapath
	function automatic logic [8:0] expect_of(input logic [55:0] b, input logic [6:0] e, input logic [2:0] pn);
		logic [2:0] op;
		logic       wr;
		logic [7:0] r;
		op = b[10:8];
		wr = (op == dpb_pkg::OP_FMT) || (op[2:1] == 2'b11);
		r = 8'h00;
		if (op == dpb_pkg::OP_NOP) return 9'h000;
		r[7] = !pn[2];
		r[5] = pn[1] && wr;
		r[3] = (op != dpb_pkg::OP_RECAL && b[31:24] > dpb_pkg::TRACK_MAX) || (op[2] && (b[37:32] == 6'h00
			|| 9'(b[37:32]) > dpb_pkg::SECTOR_MAX || 9'(b[37:32]) + 9'(b[23:16]) > dpb_pkg::SECTOR_MAX));
		if (r != 8'h00) return {1'b0, r};
		r[6] = pn[0] && wr;
		r[4] = e[0];
		r[3] = |e[6:4];
		r[2] = e[1] || |e[6:5];
		r[1] = (e[2] && op[2:1] == 2'b10) || |e[6:4];
		r[0] = (e[3] && op[2:1] == 2'b10) || e[6];
		return {1'b1, r};
	endfunction
	// one operation: block, pointer, completion, result
	task automatic run_op(input logic [55:0] b, input logic [6:0] e, input logic [2:0] pn);
		logic [31:0] q;
		logic [15:0] p;
		logic [8:0]  x;
		p = 16'($urandom);
		x = expect_of(b, e, pn);
		@(posedge core_clk);
		{drv_ready, drv_wprot, drv_wfault} <= pn;
		inj <= e;
		cap <= 29'h0;
		cap_buf <= 16'h0;
		for (int i = 0; i < dpb_pkg::BLK_LEN; i++) begin
			av(1'b1, dpb_pkg::MEM_BASE + {2'b00, p[5:0] + 6'(i), 2'b00}, {24'h0, b[8*i+:8]}, q);
		end
		av(1'b1, dpb_pkg::REG_STATUS, 32'h4, q);
		av(1'b1, dpb_pkg::REG_POINTER, {16'h0000, p}, q);
		av(1'b0, dpb_pkg::REG_POINTER, 32'h0, q);
		chk(q, {16'h0000, p});
		wait_st(dpb_pkg::ST_BUSY, 1'b1);
		wait_st(dpb_pkg::ST_BUSY, 1'b0);
		chk({3'h0, cap}, x[8] ? {4'h1, b[10:8], b[13:12], b[6], b[31:24], b[37:32], b[23:16]} : 32'h0);
		chk({16'h0, cap_buf}, x[8] ? {16'h0, b[55:40]} : 32'h0);
		av(1'b1, dpb_pkg::REG_COMMAND, 32'h1, q);
		wait_st(dpb_pkg::ST_RES_OK, 1'b1);
		av(1'b0, dpb_pkg::REG_RESULT, 32'h0, q);
		chk(q, {24'h0, x[7:0]});
		av(1'b0, dpb_pkg::REG_STATUS, 32'h0, q);
		chk({31'h0, q[dpb_pkg::ST_IRQ_SEEN]}, {31'h0, b[5:4] == dpb_pkg::IRQ_MODE_ALL});
	endtask
	////////////////////////////////////////////////////////////////////////////
	// every op code, corners, injected errors, random blocks
	initial begin
		logic [31:0] q;
		void'($urandom(32'h7390_5a9a));
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			run_op(mk(3'(i), 8'h4C, 8'hC1, 8'h33), 7'h00, 3'h4);
		end
		$display("test op codes done");
		run_op(mk(3'h4, 8'h4D, 8'h01, 8'h01), 7'h00, 3'h4);
		run_op(mk(3'h4, 8'h00, 8'h00, 8'h01), 7'h00, 3'h4);
		run_op(mk(3'h5, 8'h10, 8'h35, 8'h00), 7'h00, 3'h4);
		run_op(mk(3'h4, 8'h01, 8'h1A, 8'h1B), 7'h00, 3'h4);
		run_op(mk(3'h4, 8'h02, 8'h1A, 8'h1A), 7'h0C, 3'h4);
		run_op(mk(3'h6, 8'h03, 8'h1A, 8'h1A), 7'h0C, 3'h5);
		run_op(mk(3'h7, 8'h04, 8'h01, 8'h01), 7'h00, 3'h6);
		run_op(mk(3'h4, 8'h05, 8'h01, 8'h01), 7'h00, 3'h6);
		run_op(mk(3'h1, 8'h4D, 8'h00, 8'h00), 7'h00, 3'h4);
		run_op(mk(3'h3, 8'hFF, 8'h00, 8'h00), 7'h03, 3'h4);
		run_op(mk(3'h4, 8'h06, 8'h01, 8'h01), 7'h00, 3'h0);
		run_op(mk(3'h2, 8'h4C, 8'h00, 8'h00), 7'h10, 3'h4);
		run_op(mk(3'h4, 8'h07, 8'h02, 8'h01), 7'h20, 3'h4);
		run_op(mk(3'h5, 8'h08, 8'h03, 8'h01), 7'h40, 3'h4);
		$display("test corners done");
		for (int i = 0; i < 16; i++) begin
			run_op(mk(3'($urandom), 8'($urandom % 80), 8'($urandom), 8'($urandom % 56)),
				($urandom % 3 == 0) ? 7'($urandom) : 7'h00, {$urandom % 5 != 0, 2'($urandom)});
		end
		$display("test random done");
		av(1'b0, 10'h010, 32'h0, q);
		chk(q, 32'h0);
		av(1'b1, dpb_pkg::REG_STATUS, 32'h4, q);
		@(posedge core_clk);
		drv_ready <= ~drv_ready;
		wait_st(dpb_pkg::ST_IRQ_SEEN, 1'b1);
		$display("test ready change done");
		end_sim();
	end
endmodule
`default_nettype wire
